// *** rrd_evq_writer.sv ***
// Purpose: Circular event report queue writer into state memory bank B.
// Assumes: The memory takes one write per cycle without stalling.
// Notes: Base is in units of the smallest queue, so it is ORed with the index.

`timescale 1ns/1ps

module rrd_evq_writer
    import rrd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] cfg,
    input wire logic cfg_wr,
    input wire logic ev_valid,
    input wire logic [EVQ_DW-1:0] ev_data,
    output logic mem_wr,
    output logic [EVQ_AW-1:0] mem_addr,
    output logic [EVQ_DW-1:0] mem_data,
    output logic [EVQ_IW-1:0] wr_idx
);

    // ------------------------------------------------------------------
    // Size decode
    // ------------------------------------------------------------------
    wire logic [CFG_SIZE_W-1:0] size_code = cfg[CFG_SIZE_LSB +: CFG_SIZE_W];
    wire logic [CFG_BASE_W-1:0] base = cfg[CFG_BASE_LSB +: CFG_BASE_W];
    wire logic [15:0] span = EVQ_MIN_SPAN << size_code;
    wire logic [15:0] mask16 = span - 16'h0001;
    wire logic [EVQ_IW-1:0] mask = mask16[EVQ_IW-1:0];
    wire logic [EVQ_IW-1:0] next_idx = (wr_idx + 15'h0001) & mask;
    wire logic [EVQ_AW-1:0] slot = {base, {EVQ_MIN_LOG2{1'b0}}} | {5'h00, wr_idx};

    // ------------------------------------------------------------------
    // Write pointer
    // ------------------------------------------------------------------
    // A new location or size restarts the queue at its first entry.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_idx <= '0;
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_data <= '0;
        end else begin
            mem_wr <= ev_valid && !cfg_wr;
            if (ev_valid) begin
                mem_addr <= slot;
                mem_data <= ev_data;
            end
            if (cfg_wr) begin
                wr_idx <= '0;
            end else if (ev_valid) begin
                wr_idx <= next_idx;
            end
        end
    end

endmodule : rrd_evq_writer

// *** rrd_pkg.sv ***
// Purpose: Shared constants and types of the receive RTP disassembly front end.
// Assumes: Byte addressed register port; one 48-bit event word per queue entry.
// Notes: Queue sizes run from 256 to 32768 entries in powers of two.

package rrd_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int REG_AW = 12;
    localparam logic [11:0] REG_EVQ_CFG = 12'h720;
    localparam logic [11:0] REG_EVQ_WIDX = 12'h724;
    localparam logic [15:0] EVQ_CFG_RESET = 16'h0000;
    localparam int CFG_SIZE_LSB = 0;
    localparam int CFG_SIZE_W = 3;
    localparam int CFG_BASE_LSB = 4;
    localparam int CFG_BASE_W = 12;

    // ------------------------------------------------------------------
    // Event queue geometry
    // ------------------------------------------------------------------
    localparam int EVQ_IW = 15;
    localparam int EVQ_AW = 20;
    localparam int EVQ_MIN_LOG2 = 8;
    localparam logic [15:0] EVQ_MIN_SPAN = 16'h0100;
    localparam int EVQ_DW = 48;

    // ------------------------------------------------------------------
    // Packet checks and table lookup
    // ------------------------------------------------------------------
    localparam logic [1:0] RTP_VERSION = 2'h2;
    localparam logic [7:0] IDX_MAX = 8'hFF;
    localparam int TBL_AW = 24;
    localparam int TBL_BASE_SHIFT = 7;
    localparam int TBL_ENTRY_SHIFT = 1;

    // Table entry layout.
    localparam int ENT_KIND_LSB = 0;
    localparam int ENT_CODING_LSB = 2;
    localparam int ENT_LAW_BIT = 5;
    localparam int ENT_REPORT_BIT = 6;
    localparam int ENT_JITTER_BIT = 7;
    localparam int ENT_CHAN_LSB = 8;
    localparam logic [1:0] KIND_VOICE = 2'h0;
    localparam logic [1:0] KIND_HDLC = 2'h1;
    localparam logic [1:0] KIND_CPU = 2'h2;

    // ------------------------------------------------------------------
    // Event codes and pending slots
    // ------------------------------------------------------------------
    localparam int NPEND = 6;
    localparam int PB_CSUM = 0;
    localparam int PB_VER = 1;
    localparam int PB_LEN = 2;
    localparam int PB_SEQ = 3;
    localparam int PB_LOSS = 4;
    localparam int PB_REPORT = 5;
    localparam logic [7:0] EV_CSUM = 8'h01;
    localparam logic [7:0] EV_VER = 8'h02;
    localparam logic [7:0] EV_LEN = 8'h03;
    localparam logic [7:0] EV_SEQ = 8'h04;
    localparam logic [7:0] EV_LOSS = 8'h05;
    localparam logic [7:0] EV_REPORT = 8'h06;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TBL = 3'b010,
        ST_EVT = 3'b100
    } rrd_state_t;

endpackage : rrd_pkg

// *** rrd_rx_front.sv ***
// Purpose: Receive RTP/UDP packet treatment front end of the disassembly path.
// Assumes: Packet and connection fields arrive together, on clk, from upstream.
// Notes: One packet in flight; the table entry is fetched from outside.

`timescale 1ns/1ps

module rrd_rx_front
    import rrd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rd_data,
    input wire logic pkt_valid,
    output logic pkt_ready,
    input wire logic pkt_csum_ok,
    input wire logic [1:0] pkt_ver,
    input wire logic [10:0] pkt_hdr_len,
    input wire logic [10:0] pkt_len,
    input wire logic [6:0] pkt_pt,
    input wire logic pkt_marker,
    input wire logic [15:0] pkt_seq,
    input wire logic [15:0] pkt_udp_len,
    input wire logic conn_rtp,
    input wire logic [15:0] conn_tbl_base,
    input wire logic checksum_error_discard,
    input wire logic checksum_error_report,
    input wire logic loss_report_enable,
    input wire logic conn_init,
    input wire logic [15:0] conn_last_seq,
    output logic tbl_rd,
    output logic [TBL_AW-1:0] tbl_addr,
    input wire logic tbl_valid,
    input wire logic [15:0] tbl_entry,
    output logic conn_wr,
    output logic conn_set_init,
    output logic [15:0] conn_new_seq,
    output logic route_valid,
    output logic [3:0] route_chan,
    output logic [1:0] route_kind,
    output logic [2:0] route_coding,
    output logic route_law,
    output logic route_jitter,
    output logic pkt_drop,
    output logic evq_wr,
    output logic [EVQ_AW-1:0] evq_addr,
    output logic [EVQ_DW-1:0] evq_data
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] low_bit(input logic [NPEND-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = NPEND - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : low_bit

    function automatic logic [7:0] ev_code(input logic [2:0] slot);
        logic [7:0] c;
        unique case (slot)
            3'(PB_CSUM): c = EV_CSUM;
            3'(PB_VER): c = EV_VER;
            3'(PB_LEN): c = EV_LEN;
            3'(PB_SEQ): c = EV_SEQ;
            3'(PB_LOSS): c = EV_LOSS;
            default: c = EV_REPORT;
        endcase
        return c;
    endfunction : ev_code

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    rrd_state_t state;
    rrd_state_t next_state;
    logic [15:0] evq_cfg;
    logic [NPEND-1:0] pend;
    logic [NPEND-1:0] next_pend;
    logic [15:0] r_seq;
    logic [15:0] r_last;
    logic [7:0] r_ptm;
    logic [EVQ_IW-1:0] evq_idx;

    wire logic cfg_wr = reg_wr && (reg_addr == REG_EVQ_CFG);
    wire logic [15:0] rd_mux = (reg_addr == REG_EVQ_CFG) ? evq_cfg :
                               (reg_addr == REG_EVQ_WIDX) ? {1'b0, evq_idx} : 16'h0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            evq_cfg <= EVQ_CFG_RESET;
            reg_rd_data <= 16'h0000;
        end else begin
            if (cfg_wr) begin
                evq_cfg <= reg_wdata;
            end
            reg_rd_data <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Header checks
    // ------------------------------------------------------------------
    // Network level headers were verified upstream; only the checksum result and RTP fields are looked at.
    wire logic accept = pkt_valid && pkt_ready;
    wire logic csum_bad = !pkt_csum_ok;
    wire logic drop_csum = csum_bad && checksum_error_discard;
    wire logic ver_bad = conn_rtp && (pkt_ver != RTP_VERSION);
    wire logic len_bad = conn_rtp && (pkt_hdr_len > pkt_len);
    wire logic pass = !(drop_csum || ver_bad || len_bad);
    wire logic [15:0] seq_expect = conn_last_seq + 16'h0001;
    wire logic seq_gap = conn_rtp && conn_init && (pkt_seq != seq_expect);

    // ------------------------------------------------------------------
    // Table index and address
    // ------------------------------------------------------------------
    wire logic [7:0] len_idx = (pkt_udp_len > {8'h00, IDX_MAX}) ? IDX_MAX :
        pkt_udp_len[7:0];
    wire logic [7:0] tbl_idx = conn_rtp ? {pkt_pt, pkt_marker} : len_idx;
    wire logic [TBL_AW-1:0] tbl_base_b = TBL_AW'(conn_tbl_base) << TBL_BASE_SHIFT;
    wire logic [TBL_AW-1:0] tbl_off = TBL_AW'(tbl_idx) << TBL_ENTRY_SHIFT;

    // ------------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------------
    logic [NPEND-1:0] acc_pend;
    always_comb begin
        acc_pend = '0;
        acc_pend[PB_CSUM] = csum_bad && checksum_error_report;
        acc_pend[PB_VER] = ver_bad;
        acc_pend[PB_LEN] = len_bad;
        acc_pend[PB_SEQ] = pass && seq_gap;
        acc_pend[PB_LOSS] = pass && seq_gap && loss_report_enable;
    end

    wire logic ent_report = tbl_entry[ENT_REPORT_BIT];
    wire logic [2:0] cur_slot = low_bit(pend);
    wire logic [NPEND-1:0] pend_rest = pend & ~(NPEND'(1) << cur_slot);
    wire logic [15:0] ev_lo = (cur_slot == 3'(PB_REPORT)) ? {8'h00, r_ptm} : r_seq;
    wire logic [EVQ_DW-1:0] ev_word = {ev_code(cur_slot), r_ptm, r_last, ev_lo};
    wire logic ev_fire = (state == ST_EVT) && (pend != '0);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pend = pend;
        unique case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_pend = acc_pend;
                    if (pass) begin
                        next_state = ST_TBL;
                    end else if (acc_pend != '0) begin
                        next_state = ST_EVT;
                    end
                end
            end
            ST_TBL: begin
                if (tbl_valid) begin
                    next_pend[PB_REPORT] = ent_report;
                    if ((pend != '0) || ent_report) begin
                        next_state = ST_EVT;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_EVT: begin
                next_pend = pend_rest;
                if (pend_rest == '0) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_pend = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            pend <= '0;
            pkt_ready <= 1'b0;
        end else begin
            state <= next_state;
            pend <= next_pend;
            pkt_ready <= (next_state == ST_IDLE);
        end
    end

    // Packet context held for the table stage and for the event words.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_seq <= 16'h0000;
            r_last <= 16'h0000;
            r_ptm <= 8'h00;
            tbl_rd <= 1'b0;
            tbl_addr <= '0;
            pkt_drop <= 1'b0;
        end else begin
            tbl_rd <= accept && pass;
            pkt_drop <= accept && !pass;
            if (accept) begin
                r_seq <= pkt_seq;
                r_last <= conn_last_seq;
                r_ptm <= {pkt_pt, pkt_marker};
                tbl_addr <= tbl_base_b + tbl_off;
            end
        end
    end

    // ------------------------------------------------------------------
    // Classification, routing and connection update
    // ------------------------------------------------------------------
    wire logic ent_take = (state == ST_TBL) && tbl_valid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            route_valid <= 1'b0;
            route_chan <= 4'h0;
            route_kind <= KIND_VOICE;
            route_coding <= 3'h0;
            route_law <= 1'b0;
            route_jitter <= 1'b0;
            conn_wr <= 1'b0;
            conn_set_init <= 1'b0;
            conn_new_seq <= 16'h0000;
        end else begin
            route_valid <= ent_take;
            conn_wr <= ent_take;
            conn_set_init <= ent_take;
            if (ent_take) begin
                route_chan <= tbl_entry[ENT_CHAN_LSB +: 4];
                route_kind <= tbl_entry[ENT_KIND_LSB +: 2];
                route_coding <= tbl_entry[ENT_CODING_LSB +: 3];
                route_law <= tbl_entry[ENT_LAW_BIT];
                route_jitter <= tbl_entry[ENT_JITTER_BIT];
                conn_new_seq <= r_seq;
            end
        end
    end

    // ------------------------------------------------------------------
    // Event queue
    // ------------------------------------------------------------------
    rrd_evq_writer u_evq (
        .clk(clk),
        .nrst(nrst),
        .cfg(evq_cfg),
        .cfg_wr(cfg_wr),
        .ev_valid(ev_fire),
        .ev_data(ev_word),
        .mem_wr(evq_wr),
        .mem_addr(evq_addr),
        .mem_data(evq_data),
        .wr_idx(evq_idx)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_CSUM_DROP: assert property (accept && csum_bad && checksum_error_discard
        |=> pkt_drop && !tbl_rd)
        else $error("bad checksum with discard set was not dropped");

    AST_CSUM_KEEP: assert property (accept && csum_bad && !checksum_error_discard
        && !ver_bad && !len_bad |=> tbl_rd && !pkt_drop)
        else $error("bad checksum without discard was dropped");

    AST_VERSION: assert property (accept && conn_rtp && pkt_ver != RTP_VERSION
        |=> (pkt_drop && state == ST_EVT) ##1 evq_wr)
        else $error("wrong RTP version not dropped and reported");

    AST_LENGTH: assert property (accept && conn_rtp && pkt_hdr_len > pkt_len |=> pkt_drop)
        else $error("overlong RTP header not dropped");

    // The base in 128-byte units overlaps the index bits, so the whole sum is checked.
    AST_RTP_INDEX: assert property (accept && pass && conn_rtp
        |=> tbl_addr == ($past(TBL_AW'(conn_tbl_base)) << TBL_BASE_SHIFT)
            + (TBL_AW'($past({pkt_pt, pkt_marker})) << TBL_ENTRY_SHIFT))
        else $error("table address does not follow payload type and marker");

    AST_LEN_CLAMP: assert property (accept && pass && !conn_rtp && pkt_udp_len > 16'h00FF
        |=> tbl_addr == ($past(TBL_AW'(conn_tbl_base)) << TBL_BASE_SHIFT)
            + (TBL_AW'(IDX_MAX) << TBL_ENTRY_SHIFT))
        else $error("UDP length index not clamped");

    AST_INIT_SET: assert property (ent_take |=> conn_wr && conn_set_init && route_valid
        && conn_new_seq == $past(r_seq))
        else $error("connection not marked initialised by a good packet");

    AST_SEQ_EVENT: assert property (accept && pass && seq_gap |=> pend[PB_SEQ]
        && (pend[PB_LOSS] == $past(loss_report_enable)))
        else $error("sequence gap not queued as an event");

    AST_FIRST_NO_SEQ: assert property (accept && !conn_init
        |=> !pend[PB_SEQ] && !pend[PB_LOSS])
        else $error("first packet raised a sequence event");

    AST_CSUM_PEND: assert property (accept && csum_bad && checksum_error_report
        |=> pend[PB_CSUM])
        else $error("bad checksum not queued as an event");

    AST_CSUM_REPORT: assert property (accept && csum_bad && checksum_error_report
        && checksum_error_discard |=> pend[PB_CSUM] ##1 evq_wr && evq_data[47:40] == EV_CSUM)
        else $error("bad checksum of a discarded packet not reported first");

    AST_EVQ_WRITE: assert property (ev_fire && !cfg_wr
        |=> evq_wr && evq_data[47:40] == $past(ev_code(cur_slot)))
        else $error("pending event not written to the queue");

endmodule : rrd_rx_front

// *** rrd_rx_front_tb.sv ***
// Purpose: Self-checking bench of the receive RTP front end.
// Assumes: Inputs change and outputs are sampled on the falling edge.
// Notes: Queue configured at 256 entries, base 0x005.

`timescale 1ns/1ps

module rrd_rx_front_tb;
    import rrd_pkg::*;
    logic clk, nrst, reg_wr, pkt_valid, pkt_ready, pkt_csum_ok, pkt_marker, conn_rtp;
    logic checksum_error_discard, checksum_error_report, loss_report_enable, conn_init;
    logic tbl_rd, tbl_valid, conn_wr, conn_set_init, route_valid, route_law, route_jitter;
    logic pkt_drop, evq_wr;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rd_data, pkt_seq, pkt_udp_len, conn_tbl_base, conn_last_seq;
    logic [15:0] tbl_entry, conn_new_seq, ent;
    logic [1:0] pkt_ver, route_kind;
    logic [10:0] pkt_hdr_len, pkt_len, got_route;
    logic [6:0] pkt_pt;
    logic [23:0] tbl_addr, got_tbl;
    logic [3:0] route_chan, lat;
    logic [2:0] route_coding;
    logic [EVQ_AW-1:0] evq_addr;
    logic [EVQ_DW-1:0] evq_data;
    logic [16:0] got_conn;
    logic [67:0] evq[$];
    int n_mismatch, check_count, n_tbl, n_drop, n_conn, ev_idx;

    rrd_rx_front dut_u (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd_data, .pkt_valid,
        .pkt_ready, .pkt_csum_ok, .pkt_ver, .pkt_hdr_len, .pkt_len, .pkt_pt, .pkt_marker,
        .pkt_seq, .pkt_udp_len, .conn_rtp, .conn_tbl_base, .checksum_error_discard,
        .checksum_error_report, .loss_report_enable, .conn_init, .conn_last_seq, .tbl_rd,
        .tbl_addr, .tbl_valid, .tbl_entry, .conn_wr, .conn_set_init, .conn_new_seq,
        .route_valid, .route_chan, .route_kind, .route_coding, .route_law, .route_jitter,
        .pkt_drop, .evq_wr, .evq_addr, .evq_data);
    rrd_tbl_model tbl_u (.clk, .nrst, .tbl_rd, .entry(ent), .lat, .tbl_valid, .tbl_entry);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(negedge clk) begin
        if (evq_wr === 1'b1) evq.push_back({evq_addr, evq_data});
        if (tbl_rd === 1'b1) begin
            n_tbl++;
            got_tbl = tbl_addr;
        end
        if (route_valid === 1'b1) begin
            got_route = {route_chan, route_kind, route_coding, route_law, route_jitter};
        end
        if (conn_wr === 1'b1) begin
            n_conn++;
            got_conn = {conn_set_init, conn_new_seq};
        end
        if (pkt_drop === 1'b1) n_drop++;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [67:0] exp, input logic [67:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        reg_addr = a;
        @(negedge clk);
        chk("register", exp, reg_rd_data);
    endtask : rd

    task automatic pk(input logic [15:0] last, input logic [15:0] seq, input logic [15:0] e);
        pkt_ver = RTP_VERSION;
        pkt_hdr_len = 11'd12;
        pkt_len = 11'd60;
        pkt_csum_ok = 1'b1;
        conn_rtp = 1'b1;
        conn_init = 1'b1;
        checksum_error_discard = 1'b0;
        checksum_error_report = 1'b0;
        loss_report_enable = 1'b0;
        conn_last_seq = last;
        pkt_seq = seq;
        ent = e;
    endtask : pk

    // Offers the packet, waits for acceptance and lets every answer land.
    task automatic go(input int nev);
        int n;
        evq.delete();
        n_tbl = 0;
        n_drop = 0;
        n_conn = 0;
        n = 0;
        pkt_valid = 1'b1;
        // Ready is looked at while settled, so the next rising edge is the accepting one.
        while (pkt_ready !== 1'b1 && n < 40) begin
            n++;
            @(negedge clk);
        end
        @(negedge clk);
        pkt_valid = 1'b0;
        // Long enough for the slowest table answer plus three events.
        repeat (24) @(negedge clk);
        chk("event count", nev, evq.size());
        chk("ready", 1'b1, pkt_ready);
    endtask : go

    task automatic fate(input int drop);
        chk("drop", drop, n_drop);
        chk("table reads", 1 - drop, n_tbl);
        chk("write back", 1 - drop, n_conn);
    endtask : fate

    task automatic ev(input int k, input logic [7:0] code, input logic [15:0] low);
        logic [67:0] e;
        e = {{12'h005, 8'h00} | EVQ_AW'(ev_idx), code, pkt_pt, pkt_marker, conn_last_seq, low};
        ev_idx++;
        chk("event", e, (k < evq.size()) ? evq[k] : 68'h0);
    endtask : ev

    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        {nrst, reg_wr, pkt_valid, pkt_marker, reg_addr, reg_wdata, pkt_pt, pkt_udp_len} = '0;
        conn_tbl_base = 16'h0123;
        lat = 4'h1;
        pk(16'h0000, 16'h0000, 16'h0000);
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        rd(REG_EVQ_CFG, EVQ_CFG_RESET);
        wr(REG_EVQ_CFG, 16'h0050);
        rd(REG_EVQ_CFG, 16'h0050);
        wr(12'h010, 16'hFFFF);
        rd(12'h010, 16'h0000);
        $display("test registers done");
        pk(16'h0000, 16'h0100, {4'h0, 4'h9, 1'b1, 1'b0, 1'b1, 3'h1, KIND_VOICE});
        conn_init = 1'b0;
        pkt_pt = 7'h12;
        pkt_marker = 1'b1;
        go(0);
        chk("table address", {conn_tbl_base, 7'h00} + 24'h00004A, got_tbl);
        chk("first write back", {1'b1, 16'h0100}, got_conn);
        chk("route", {4'h9, KIND_VOICE, 3'h1, 1'b1, 1'b1}, got_route);
        $display("test first packet done");
        for (int i = 0; i < 6; i++) begin
            pk(16'hFFFD + 16'(i), 16'hFFFE + 16'(i),
                {4'h0, 4'(15 - i), 1'(i), 1'b0, 1'(i >> 1), 3'(i), 2'(i % 3)});
            lat = 4'(i * 2);
            go(0);
            chk("route", {4'(15 - i), 2'(i % 3), 3'(i), 1'(i >> 1), 1'(i)},
                got_route);
            chk("new seq", pkt_seq, got_conn[15:0]);
        end
        $display("test codings done");
        pk(16'h0010, 16'h0011, 16'h0000);
        pkt_ver = 2'h1;
        go(1);
        ev(0, EV_VER, pkt_seq);
        fate(1);
        pk(16'h0011, 16'h0012, 16'h0000);
        pkt_hdr_len = 11'd61;
        go(1);
        ev(0, EV_LEN, pkt_seq);
        fate(1);
        pkt_hdr_len = 11'd60;
        go(0);
        fate(0);
        pk(16'h0012, 16'h0013, 16'h0000);
        pkt_csum_ok = 1'b0;
        checksum_error_discard = 1'b1;
        checksum_error_report = 1'b1;
        go(1);
        ev(0, EV_CSUM, pkt_seq);
        fate(1);
        checksum_error_report = 1'b0;
        go(0);
        fate(1);
        checksum_error_discard = 1'b0;
        go(0);
        fate(0);
        checksum_error_report = 1'b1;
        go(1);
        ev(0, EV_CSUM, pkt_seq);
        fate(0);
        $display("test drops done");
        for (int l = 0; l < 2; l++) begin
            pk(16'h0010, 16'h0013, 16'h0040);
            pkt_pt = 7'h60;
            pkt_marker = 1'b0;
            loss_report_enable = 1'(l);
            go(2 + l);
            ev(0, EV_SEQ, pkt_seq);
            if (l == 1) ev(1, EV_LOSS, pkt_seq);
            ev(1 + l, EV_REPORT, {8'h00, pkt_pt, pkt_marker});
        end
        $display("test sequence gap done");
        for (int u = 0; u < 2; u++) begin
            pk(16'h0000, 16'h0000, 16'h0000);
            conn_rtp = 1'b0;
            pkt_udp_len = u ? 16'd300 : 16'd37;
            go(0);
            chk("udp index", {conn_tbl_base, 7'h00} + (u ? 24'h0001FE : 24'h00004A),
                got_tbl);
        end
        rd(REG_EVQ_WIDX, 16'(ev_idx));
        $display("test udp only done");
        results();
    end
endmodule : rrd_rx_front_tb

// *** rrd_tbl_model.sv ***
// Purpose: Table memory partner of the receive front end.
// Assumes: One read in flight; entry value is supplied by the bench.
// Notes: The data lines toggle while no entry is presented.

`timescale 1ns/1ps

module rrd_tbl_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tbl_rd,
    input wire logic [15:0] entry,
    input wire logic [3:0] lat,
    output logic tbl_valid,
    output logic [15:0] tbl_entry
);
    logic busy;
    logic [3:0] cnt;
    logic hit;

    assign hit = busy && (cnt == 4'h0);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            tbl_valid <= 1'b0;
            tbl_entry <= 16'h0000;
        end else begin
            tbl_valid <= hit;
            if (tbl_rd) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (hit) begin
                busy <= 1'b0;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
            // A stale entry must never look valid, so idle data is inverted every cycle.
            tbl_entry <= hit ? entry : ~tbl_entry;
        end
    end
endmodule : rrd_tbl_model
